// ===== src/mfm_regs.sv
// Manufacturer information strings and the device mode word, reached by command code.
// Assumes host-side logic on lk_clk issues one command at a time and that unlock attempts
// arrive from logic on ref_clk.
`timescale 1ns/1ns

// What this block does
// - maker code read-only single character
// - model code read-only single character
// - revision: hardware upper, firmware lower byte
// - site text writable, eight characters, readable
// - date text writable, eight characters, readable
// - strings persisted only on store-all command
// - strings default to text 10101010
// - serial text writable, eight characters, readable
// - serial upper four bytes form password
// - serial lower four bytes ignored at unlock
// - mode bits 15:14, 9:8 read zero
// - mode bit 13 enables alert response
// - mode bit 12 picks sync master/slave
// - bit 11 set-clear-set in 8ms: soft reset
// - bit 10 set-clear-set in 8ms: lock
// - correct password clears lock bit
// - bits 7:6 choose 1-8 us conversion
// - bits 5:4 choose ADC averaging
// - bits 3:0 give 2^n current averaging
// - status lock flag unlatched, no alert
module mfm_regs import mfm_pkg::*; #(
   parameter int SEQ_CYC = SEQ_WIN_CYC,          // Sequence window in core cycles
   parameter logic [7:0] MAKER_CODE = 8'h41,     // Arbitrary value
   parameter logic [7:0] MODEL_CODE = 8'h42,     // Arbitrary value
   parameter logic [7:0] HW_REV = 8'h31,         // Arbitrary value
   parameter logic [7:0] FW_REV = 8'h30          // Arbitrary value
)(
   input wire logic ref_clk,                     // Core clock, 10 MHz
   input wire logic rst,                         // Synchronous reset, active high
   input wire logic lk_clk,                      // Command link clock
   input wire logic lk_valid,                    // Command offered
   input wire mfm_req_t lk_req,                  // Command code, direction, data
   output logic lk_busy,                         // Command in flight
   output logic lk_done,                         // Answer ready, one pulse
   output mfm_rsp_t lk_rsp,                      // Read data and error
   input wire logic unlock_try,                  // Password attempt strobe
   input wire logic [31:0] unlock_pw,            // Password offered
   input wire logic sync_i,                      // Sync pin level
   output logic sync_o,                          // Sync pin drive
   output logic sync_oe,                         // Sync pin enable
   output logic sync_lost,                       // Slave sees no sync clock
   output logic alert_resp_en,                   // Answer alert response address
   output logic soft_reset,                      // Soft reset pulse
   output logic locked,                          // Password protected
   output logic [7:0] mfr_status,                // Global manufacturer status byte
   output logic nv_store,                        // Persist strings, one pulse
   output logic [63:0] site_text,                // Site string
   output logic [63:0] date_text,                // Date string
   output logic [63:0] serial_text,              // Serial string
   output logic [7:0] adc_conv_cycles,           // Conversion time in core cycles
   output logic [1:0] adc_avg_sel,               // Averaging selection
   output logic [3:0] current_avg_depth          // Log2 of current averaging depth
);

   localparam int TMR_W = $clog2(SEQ_CYC + 1);
   localparam logic [TMR_W-1:0] TMR_LAST = TMR_W'(SEQ_CYC - 1);

   // True for any command the block answers
   function automatic logic cmd_known(input logic [7:0] c);
      return c inside {CMD_STORE_ALL, CMD_MAKER, CMD_MODEL, CMD_REV, CMD_SITE, CMD_DATE, CMD_SERIAL,
                       CMD_MODE};
   endfunction

   // True for commands that must not be written
   function automatic logic cmd_ro(input logic [7:0] c);
      return c inside {CMD_MAKER, CMD_MODEL, CMD_REV};
   endfunction

   // Conversion time doubles per step from the base
   function automatic logic [7:0] conv_cycles(input logic [1:0] sel);
      return 8'(CONV_BASE_CYC) << sel;
   endfunction

   // Link domain
   logic lrst_s1_q, lrst_q;
   logic ak_s1_q, ak_s2_q, ak_s3_q;
   logic req_tgl_q, busy_q, done_q;
   mfm_req_t hold_q;
   mfm_rsp_t lrsp_q;
   // Core domain
   logic rq_s1_q, rq_s2_q, rq_s3_q;
   logic ack_tgl_q;
   mfm_rsp_t rsp_q;
   logic acc_go, acc_bad, wr_ok, mode_wr, unlock_ok;
   logic [63:0] rd_data;
   logic [15:0] mode_q;
   logic [63:0] site_q, date_q, serial_q;
   logic locked_q, srst_q, store_q;
   mfm_seq_t seq_q [2];
   logic [TMR_W-1:0] tmr_q [2];
   logic [1:0] seq_fire, seq_wbit;
   logic [7:0] sync_cnt_q;
   logic [9:0] lost_cnt_q;
   logic sync_o_q, sync_oe_q, sync_lost_q;
   logic sy_s1_q, sy_s2_q, sy_s3_q;
   logic [7:0] conv_q;

   // Reset is carried into the link domain through two flops
   always_ff @(posedge lk_clk)
   begin
      lrst_s1_q <= rst;
      lrst_q <= lrst_s1_q;
   end

   // Answer toggle synchroniser on the link side
   always_ff @(posedge lk_clk)
   begin
      if (lrst_q)
      begin
         ak_s1_q <= 1'b0;
         ak_s2_q <= 1'b0;
         ak_s3_q <= 1'b0;
      end
      else
      begin
         ak_s1_q <= ack_tgl_q;
         ak_s2_q <= ak_s1_q;
         ak_s3_q <= ak_s2_q;
      end
   end

   // Link side takes one command, holds it steady until the core answers
   always_ff @(posedge lk_clk)
   begin
      if (lrst_q)
      begin
         req_tgl_q <= 1'b0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
         hold_q <= '0;
         lrsp_q <= '0;
      end
      else
      begin
         done_q <= 1'b0;
         if (lk_valid && !busy_q)
         begin
            hold_q <= lk_req;
            req_tgl_q <= ~req_tgl_q;
            busy_q <= 1'b1;
         end
         else if (busy_q && (ak_s2_q ^ ak_s3_q))
         begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
            lrsp_q <= rsp_q;   // Stable: core only changes it on the next request
         end
      end
   end

   assign lk_busy = busy_q;
   assign lk_done = done_q;
   assign lk_rsp = lrsp_q;

   // Request toggle synchroniser on the core side
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rq_s1_q <= 1'b0;
         rq_s2_q <= 1'b0;
         rq_s3_q <= 1'b0;
      end
      else
      begin
         rq_s1_q <= req_tgl_q;
         rq_s2_q <= rq_s1_q;
         rq_s3_q <= rq_s2_q;
      end
   end

   // Access decode; hold_q is stable while the toggle is in flight
   assign acc_go = rq_s2_q ^ rq_s3_q;
   assign acc_bad = !cmd_known(hold_q.cmd) || (hold_q.wr && cmd_ro(hold_q.cmd)) ||
                    (!hold_q.wr && hold_q.cmd == CMD_STORE_ALL);
   assign wr_ok = acc_go && hold_q.wr && !acc_bad;
   assign mode_wr = wr_ok && hold_q.cmd == CMD_MODE;
   assign unlock_ok = unlock_try && locked_q && unlock_pw == serial_q[63:PW_LSB];

   // Read data by command, narrow values in the low bits
   always_comb
   begin
      rd_data = '0;
      unique case (hold_q.cmd)
         CMD_MAKER: rd_data = {56'h0, MAKER_CODE};
         CMD_MODEL: rd_data = {56'h0, MODEL_CODE};
         CMD_REV: rd_data = {48'h0, HW_REV, FW_REV};
         CMD_SITE: rd_data = site_q;
         CMD_DATE: rd_data = date_q;
         CMD_SERIAL: rd_data = serial_q;
         CMD_MODE: rd_data = {48'h0, mode_q & MODE_WMASK};
         default: rd_data = '0;
      endcase
   end

   // Answer capture and toggle back to the link
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         rsp_q <= '0;
         ack_tgl_q <= 1'b0;
      end
      else if (acc_go)
      begin
         rsp_q.err <= acc_bad;
         rsp_q.rdata <= hold_q.wr ? 64'h0 : rd_data;
         ack_tgl_q <= ~ack_tgl_q;
      end
   end

   // Strings start from the factory text and follow host writes
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         site_q <= TEXT_DFLT;
         date_q <= TEXT_DFLT;
         serial_q <= TEXT_DFLT;
      end
      else if (wr_ok)
      begin
         if (hold_q.cmd == CMD_SITE)
            site_q <= hold_q.wdata;
         if (hold_q.cmd == CMD_DATE)
            date_q <= hold_q.wdata;
         if (hold_q.cmd == CMD_SERIAL)
            serial_q <= hold_q.wdata;
      end
   end

   // Persisting is a separate request; a string write alone never triggers it
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         store_q <= 1'b0;
      else
         store_q <= wr_ok && hold_q.cmd == CMD_STORE_ALL;
   end

   // Mode word; a host write of the lock bit wins over an unlock in the same cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         mode_q <= MODE_RST;
      else if (mode_wr)
         mode_q <= hold_q.wdata[15:0] & MODE_WMASK;
      else if (unlock_ok)
         mode_q[MODE_LOCK_BIT] <= 1'b0;
   end

   // Bit values seen by the two sequence trackers: 0 soft reset, 1 lock
   assign seq_wbit = {hold_q.wdata[MODE_LOCK_BIT], hold_q.wdata[MODE_SRST_BIT]};

   // Completion is the final set while the tracker waits in the cleared state
   always_comb
   begin
      for (int i = 0; i < 2; i++)
         seq_fire[i] = mode_wr && seq_q[i] == SQ_CLR && seq_wbit[i];
   end

   // Set/clear/set trackers; a write in the last allowed cycle still counts
   always_ff @(posedge ref_clk)
   begin
      for (int i = 0; i < 2; i++)
      begin
         if (rst)
         begin
            seq_q[i] <= SQ_IDLE;
            tmr_q[i] <= '0;
         end
         else
         begin
            tmr_q[i] <= (seq_q[i] == SQ_IDLE) ? '0 : tmr_q[i] + 1'b1;
            if (mode_wr)
            begin
               unique case (seq_q[i])
                  SQ_IDLE: if (seq_wbit[i]) seq_q[i] <= SQ_SET1;
                  SQ_SET1: if (!seq_wbit[i]) seq_q[i] <= SQ_CLR;
                  SQ_CLR: if (seq_wbit[i]) seq_q[i] <= SQ_IDLE;
                  default: seq_q[i] <= SQ_IDLE;   // Unused fourth code recovers to idle
               endcase
            end
            else if (seq_q[i] != SQ_IDLE && tmr_q[i] == TMR_LAST)
               seq_q[i] <= SQ_IDLE;
         end
      end
   end

   // Soft reset pulse and lock state; locking wins over a same-cycle unlock
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         srst_q <= 1'b0;
         locked_q <= 1'b0;
      end
      else
      begin
         srst_q <= seq_fire[0];
         if (seq_fire[1])
            locked_q <= 1'b1;
         else if (unlock_ok)
            locked_q <= 1'b0;
      end
   end

   // Sync master clock divider, runs free so a role change needs no restart
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sync_cnt_q <= '0;
         sync_o_q <= 1'b0;
         sync_oe_q <= 1'b0;
      end
      else
      begin
         sync_oe_q <= !mode_q[MODE_SYNC_BIT];
         if (sync_cnt_q == 8'(SYNC_HALF_CYC - 1))
         begin
            sync_cnt_q <= '0;
            sync_o_q <= ~sync_o_q;
         end
         else
            sync_cnt_q <= sync_cnt_q + 8'h01;
      end
   end

   // Slave watches the incoming sync clock; the pin passes two flops first
   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         sy_s1_q <= 1'b0;
         sy_s2_q <= 1'b0;
         sy_s3_q <= 1'b0;
         lost_cnt_q <= '0;
         sync_lost_q <= 1'b0;
      end
      else
      begin
         sy_s1_q <= sync_i;
         sy_s2_q <= sy_s1_q;
         sy_s3_q <= sy_s2_q;
         if (!mode_q[MODE_SYNC_BIT] || (sy_s2_q ^ sy_s3_q))
         begin
            lost_cnt_q <= '0;
            sync_lost_q <= 1'b0;
         end
         else if (lost_cnt_q == 10'(SYNC_LOST_CYC - 1))
            sync_lost_q <= 1'b1;
         else
            lost_cnt_q <= lost_cnt_q + 10'h001;
      end
   end

   // Conversion time decoded once per cycle
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         conv_q <= conv_cycles(MODE_RST[MODE_TIME_LSB +: 2]);
      else
         conv_q <= conv_cycles(mode_q[MODE_TIME_LSB +: 2]);
   end

   // Outputs straight from flops
   assign sync_o = sync_o_q;
   assign sync_oe = sync_oe_q;
   assign sync_lost = sync_lost_q;
   assign alert_resp_en = mode_q[MODE_ALERT_BIT];
   assign soft_reset = srst_q;
   assign locked = locked_q;
   assign mfr_status = {locked_q, 7'h00};
   assign nv_store = store_q;
   assign site_text = site_q;
   assign date_text = date_q;
   assign serial_text = serial_q;
   assign adc_conv_cycles = conv_q;
   assign adc_avg_sel = mode_q[MODE_AVG_LSB +: 2];
   assign current_avg_depth = mode_q[MODE_DEPTH_LSB +: 4];

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   sequence s_mode_wr(int b, logic v);
      mode_wr && hold_q.wdata[b] == v;
   endsequence

   sequence s_rd(logic [7:0] c);
      acc_go && !hold_q.wr && hold_q.cmd == c;
   endsequence

   maker_read_a: assert property (s_rd(CMD_MAKER) |=> rsp_q.rdata == {56'h0, MAKER_CODE} && !rsp_q.err)
      else $error("maker code read wrong");
   model_ro_a: assert property (acc_go && hold_q.wr && hold_q.cmd == CMD_MODEL |=> rsp_q.err)
      else $error("model code write not refused");
   rev_read_a: assert property (s_rd(CMD_REV) |=> rsp_q.rdata[15:8] == HW_REV && rsp_q.rdata[7:0] == FW_REV)
      else $error("revision read wrong");
   serial_wr_a: assert property (wr_ok && hold_q.cmd == CMD_SERIAL |=> serial_q == $past(hold_q.wdata))
      else $error("serial write lost");
   store_cause_a: assert property ($rose(store_q) |-> $past(wr_ok && hold_q.cmd == CMD_STORE_ALL))
      else $error("store without command");
   mode_zero_a: assert property (s_rd(CMD_MODE) |=> rsp_q.rdata[15:14] == 2'b00 && rsp_q.rdata[9:8] == 2'b00)
      else $error("mode reserved bits not zero");
   alert_follow_a: assert property (s_mode_wr(MODE_ALERT_BIT, 1'b1) |=> alert_resp_en)
      else $error("alert enable not taken");
   srst_fire_a: assert property (seq_q[0] == SQ_CLR ##0 s_mode_wr(MODE_SRST_BIT, 1'b1) |=> soft_reset ##1 !soft_reset)
      else $error("soft reset pulse wrong");
   lock_cause_a: assert property ($rose(locked_q) |-> $past(seq_q[1] == SQ_CLR && mode_wr && seq_wbit[1]))
      else $error("lock without full sequence");
   unlock_clr_a: assert property (unlock_ok && !mode_wr && !seq_fire[1] |=> !locked_q && !mode_q[MODE_LOCK_BIT])
      else $error("unlock did not clear lock");
   conv_map_a: assert property (mode_q[7:6] == 2'b11 |=> conv_q == 8'(8 * CONV_BASE_CYC))
      else $error("conversion time wrong");
   status_lock_a: assert property (mfr_status[STAT_LOCK_BIT] == locked_q)
      else $error("status lock flag wrong");

endmodule // mfm_regs

// ===== shared/mfm_pkg.sv
// Constants and carrier types for the manufacturer information and mode register set.
// Assumes a 10 MHz core clock and a command port driven by host-side logic on its own clock.
package mfm_pkg;

   // Core clock period and derived timing
   localparam int CLK_NS = 100;
   localparam int SEQ_WIN_NS = 8_000_000;                 // Set/clear/set window, 8 ms
   localparam int SEQ_WIN_CYC = SEQ_WIN_NS / CLK_NS;      // Longest time, rounded down
   localparam int SYNC_HZ = 20_000;                       // Sync pin clock rate
   localparam int SYNC_HALF_CYC = (1_000_000_000 / (2 * SYNC_HZ)) / CLK_NS;
   localparam int SYNC_LOST_CYC = 4 * SYNC_HALF_CYC;      // Two missing periods
   localparam int CONV_BASE_NS = 1_000;                   // Shortest conversion, 1 us
   localparam int CONV_BASE_CYC = (CONV_BASE_NS + CLK_NS - 1) / CLK_NS;

   // Command codes
   localparam logic [7:0] CMD_STORE_ALL = 8'h11;
   localparam logic [7:0] CMD_MAKER = 8'h99;
   localparam logic [7:0] CMD_MODEL = 8'h9A;
   localparam logic [7:0] CMD_REV = 8'h9B;
   localparam logic [7:0] CMD_SITE = 8'h9C;
   localparam logic [7:0] CMD_DATE = 8'h9D;
   localparam logic [7:0] CMD_SERIAL = 8'h9E;
   localparam logic [7:0] CMD_MODE = 8'hD1;

   // Mode word layout
   localparam int MODE_ALERT_BIT = 13;
   localparam int MODE_SYNC_BIT = 12;
   localparam int MODE_SRST_BIT = 11;
   localparam int MODE_LOCK_BIT = 10;
   localparam int MODE_TIME_LSB = 6;
   localparam int MODE_AVG_LSB = 4;
   localparam int MODE_DEPTH_LSB = 0;
   localparam logic [15:0] MODE_RST = 16'h0000;
   localparam logic [15:0] MODE_WMASK = 16'h3CFF;         // 15:14 and 9:8 always zero

   // Text defaults and status layout
   localparam logic [63:0] TEXT_DFLT = 64'h3130313031303130; // "10101010"
   localparam int PW_LSB = 32;                             // Upper four bytes are the password
   localparam int STAT_LOCK_BIT = 7;

   // Command carried from the link side
   typedef struct packed {
      logic wr;
      logic [7:0] cmd;
      logic [63:0] wdata;
   } mfm_req_t;

   // Answer carried back to the link side
   typedef struct packed {
      logic err;
      logic [63:0] rdata;
   } mfm_rsp_t;

   // Set/clear/set sequence tracker
   typedef enum logic [1:0] {SQ_IDLE, SQ_SET1, SQ_CLR} mfm_seq_t;

endpackage

// ===== test/mfm_host.sv
// Host-side command model: offers one command at a time on the link clock.
// Assumes the register set takes a command while not busy and answers with a one-cycle done.
`timescale 1ns/1ns
module mfm_host import mfm_pkg::*; (
   input wire logic lk_clk, // Link clock
   input wire logic lk_busy, // Command in flight
   input wire logic lk_done, // Answer ready
   input wire mfm_rsp_t lk_rsp, // Answer word
   output logic lk_valid, // Command offered
   output mfm_req_t lk_req // Command word
);
   // Idle link at time zero
   initial
   begin
      lk_valid = 1'b0;
      lk_req = '0;
   end

   // Issues only what the bench asks, so no mode writes with supplies up
   // Offer until taken, hold the word until the answer, then scramble it so nothing stale shows
   task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [63:0] wd, output mfm_rsp_t rsp);
      int n;
      @(negedge lk_clk);
      lk_req = '{wr: wr, cmd: cmd, wdata: wd};
      lk_valid = 1'b1;
      n = 0;
      // Busy seen high half a cycle after the taking edge means the word was taken
      do
      begin
         @(negedge lk_clk);
         n++;
      end
      while (lk_busy !== 1'b1 && n < 100);
      lk_valid = 1'b0;
      rsp = '{err: 1'bx, rdata: {64{1'bx}}};
      // Done stands for one whole link cycle, so a falling edge always lands inside it
      for (n = 0; n < 100; n++)
      begin
         @(negedge lk_clk);
         if (lk_done === 1'b1)
         begin
            rsp = lk_rsp;
            break;
         end
      end
      @(negedge lk_clk);
      lk_req = ~lk_req;
   endtask
endmodule // mfm_host

// ===== test/testbench.sv
// Self-checking bench for the information strings and mode word, reached by command code.
// Assumes the host model drives the link; the bench drives reset and unlock strobes.
`timescale 1ns/1ns
module testbench import mfm_pkg::*;;
   localparam int SEQ = 200; // Short window keeps the run brief
   localparam logic [7:0] MK = 8'h5C; // Arbitrary value
   localparam logic [7:0] MD = 8'h6E; // Arbitrary value
   localparam logic [7:0] HW = 8'h33; // Arbitrary value
   localparam logic [7:0] FW = 8'h37; // Arbitrary value
   localparam logic [63:0] DFLT = 64'h3130313031303130; // Text 10101010
   localparam logic [63:0] SER = 64'h5A5A3C3C11223344;
   logic ref_clk, rst, lk_clk, lk_valid, lk_busy, lk_done, unlock_try, sync_i;
   mfm_req_t lk_req;
   mfm_rsp_t lk_rsp, rsp;
   logic [31:0] unlock_pw;
   logic sync_o, sync_oe, sync_lost, alert_resp_en, soft_reset, locked, nv_store;
   logic [7:0] mfr_status, adc_conv_cycles;
   logic [1:0] adc_avg_sel;
   logic [3:0] current_avg_depth;
   logic [63:0] site_text, date_text, serial_text;
   int bad_count = 0, tests_run = 0, n_srst = 0, n_store = 0, cyc = 0;

   // Core clock 100 ns
   initial
   begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   // Link clock 15 ns, offset from the core clock
   initial
   begin
      lk_clk = 1'b0;
      #3;
      forever
      begin
         #7 lk_clk = 1'b1;
         #8 lk_clk = 1'b0;
      end
   end

   mfm_regs #(.SEQ_CYC(SEQ), .MAKER_CODE(MK), .MODEL_CODE(MD), .HW_REV(HW), .FW_REV(FW)) uut (
      .ref_clk(ref_clk), .rst(rst), .lk_clk(lk_clk), .lk_valid(lk_valid), .lk_req(lk_req),
      .lk_busy(lk_busy), .lk_done(lk_done), .lk_rsp(lk_rsp), .unlock_try(unlock_try),
      .unlock_pw(unlock_pw), .sync_i(sync_i), .sync_o(sync_o), .sync_oe(sync_oe),
      .sync_lost(sync_lost), .alert_resp_en(alert_resp_en), .soft_reset(soft_reset),
      .locked(locked), .mfr_status(mfr_status), .nv_store(nv_store), .site_text(site_text),
      .date_text(date_text), .serial_text(serial_text), .adc_conv_cycles(adc_conv_cycles),
      .adc_avg_sel(adc_avg_sel), .current_avg_depth(current_avg_depth)
   );

   mfm_host host (
      .lk_clk(lk_clk), .lk_busy(lk_busy), .lk_done(lk_done), .lk_rsp(lk_rsp),
      .lk_valid(lk_valid), .lk_req(lk_req)
   );

   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Pulse counters and a cycle ceiling so a hung link cannot stall the run
   // Counted on the falling edge, where one-cycle pulses are settled
   always @(negedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (!rst && soft_reset === 1'b1)
         n_srst <= n_srst + 1;
      if (!rst && nv_store === 1'b1)
         n_store <= n_store + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         print_verdict;
      end
   end

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wref(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   // Write, then let the core-side outputs settle
   task automatic wr(input logic [7:0] cmd, input logic [63:0] d);
      host.xfer(1'b1, cmd, d, rsp);
      wref(3);
   endtask

   task automatic rd_chk(input string name, input logic [7:0] cmd, input logic [63:0] exp);
      host.xfer(1'b0, cmd, 64'h0, rsp);
      check(name, 64'(rsp.err), 64'h0);
      check(name, rsp.rdata, exp);
   endtask

   task automatic try_pw(input logic [31:0] pw);
      @(negedge ref_clk);
      unlock_try = 1'b1;
      unlock_pw = pw;
      @(negedge ref_clk);
      unlock_try = 1'b0;
      unlock_pw = ~pw;
      wref(2);
   endtask

   // Main sequence
   initial
   begin
      logic [1:0] s;
      int n;
      rst = 1'b1;
      unlock_try = 1'b0;
      unlock_pw = 32'h0;
      sync_i = 1'b0;
      wref(20);
      rst = 1'b0;
      wref(2);
      check("reset_outs", 64'({alert_resp_en, sync_oe, locked, mfr_status, adc_conv_cycles}),
            64'({1'b0, 1'b1, 1'b0, 8'h00, 8'h0A}));
      rd_chk("maker", CMD_MAKER, 64'(MK));
      rd_chk("model", CMD_MODEL, 64'(MD));
      rd_chk("revision", CMD_REV, 64'({HW, FW}));
      rd_chk("site_dflt", CMD_SITE, DFLT);
      rd_chk("date_dflt", CMD_DATE, DFLT);
      rd_chk("serial_dflt", CMD_SERIAL, DFLT);
      // Read-only codes refuse writes; maker and revision keep their value
      for (int i = 0; i < 3; i++)
      begin
         host.xfer(1'b1, CMD_MAKER + 8'(i), 64'hFFFF, rsp);
         check("ro_write_err", 64'(rsp.err), 64'h1);
      end
      rd_chk("maker_kept", CMD_MAKER, 64'(MK));
      rd_chk("rev_kept", CMD_REV, 64'({HW, FW}));
      // Strings write and read back, persisted only on store-all
      wr(CMD_SITE, 64'h4C41422D57455354);
      wr(CMD_DATE, 64'h3230323430333135);
      wr(CMD_SERIAL, SER);
      check("no_store", 64'(n_store), 64'h0);
      rd_chk("site", CMD_SITE, 64'h4C41422D57455354);
      rd_chk("date", CMD_DATE, 64'h3230323430333135);
      rd_chk("serial", CMD_SERIAL, SER);
      check("site_out", site_text, 64'h4C41422D57455354);
      check("date_out", date_text, 64'h3230323430333135);
      check("serial_out", serial_text, SER);
      wr(CMD_STORE_ALL, 64'h0);
      check("store", 64'(n_store), 64'h1);
      // Mode word: fixed-zero bits, alert and sync role
      wr(CMD_MODE, 64'hFFFFFFFFFFFFF3FF);
      rd_chk("mode_mask", CMD_MODE, 64'h30FF);
      check("alert_on", 64'({alert_resp_en, sync_oe}), 64'h2);
      wr(CMD_MODE, 64'h0);
      check("alert_off", 64'({alert_resp_en, sync_oe}), 64'h1);
      // Every conversion time and ADC averaging code, four current averaging depths
      for (int k = 0; k < 4; k++)
      begin
         s = 2'(k);
         wr(CMD_MODE, 64'({s, s, s, s}));
         check("conv", 64'(adc_conv_cycles), 64'(10 << k));
         check("avg", 64'(adc_avg_sel), 64'(s));
         check("depth", 64'(current_avg_depth), 64'({s, s}));
      end
      // Master sync half period: 25 us is 250 core cycles
      n = 0;
      @(posedge sync_o);
      @(negedge ref_clk);
      while (sync_o === 1'b1 && n < 600)
      begin
         n++;
         @(negedge ref_clk);
      end
      check("sync_half", 64'(n), 64'd250);
      // Slave role: pin released, a silent pin is flagged, an edge clears the flag
      wr(CMD_MODE, 64'h1000);
      wref(1010);
      check("slave_lost", 64'({sync_oe, sync_lost}), 64'h1);
      sync_i = 1'b1;
      wref(4);
      check("slave_edge", 64'(sync_lost), 64'h0);
      wr(CMD_MODE, 64'h0);
      // Soft reset: set, clear, set inside the window
      wr(CMD_MODE, 64'h0800);
      wr(CMD_MODE, 64'h0);
      wr(CMD_MODE, 64'h0800);
      check("srst", 64'(n_srst), 64'h1);
      // Lock sequence stretched past the window must not lock
      wr(CMD_MODE, 64'h0400);
      wref(SEQ + 50);
      wr(CMD_MODE, 64'h0);
      wr(CMD_MODE, 64'h0400);
      check("slow_lock", 64'(locked), 64'h0);
      wr(CMD_MODE, 64'h0);
      wref(SEQ + 50);
      wr(CMD_MODE, 64'h0400);
      wr(CMD_MODE, 64'h0);
      wr(CMD_MODE, 64'h0400);
      check("locked", 64'({locked, mfr_status}), 64'h180);
      try_pw(SER[31:0]);
      check("low_pw", 64'(locked), 64'h1);
      try_pw(32'h5A5A3C3D);
      check("bad_pw", 64'(locked), 64'h1);
      try_pw(SER[63:32]);
      check("unlock", 64'({locked, mfr_status}), 64'h0);
      rd_chk("lock_bit", CMD_MODE, 64'h0);
      print_verdict;
   end
endmodule // testbench
